// ===== sim/tb_top.sv
/*
 self-checking bench for acr_top: bus accesses, result strobes,
 vector priority and interrupt line against an integer model.
 assumes acr_params.svh offsets and the one-wait-cycle avalon slave.
*/
`timescale 1ns/100ps
`include "acr_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;

    logic                 sys_clk;
    logic                 reset_n;
    logic [7:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    acr_pkg::acr_result_t convResult;
    logic                 convBusy;
    logic                 memOverflow;
    logic                 timeOverflow;
    logic [3:0]           clkSrcOneHot;
    logic [1:0]           seqModeSel;
    logic [7:0]           curMemCtl;
    logic                 ovIrqEnable;
    logic                 tovIrqEnable;
    logic                 irq;
    int                   n_mismatch;
    int                   check_count;
    logic [31:0]          rd;
    logic [15:0]          ieM;
    logic [15:0]          ifgM;
    logic [3:0]           idx;
    logic [11:0]          res;
    logic                 stM;

    acr_top u_acr_top (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .convResult(convResult), .convBusy(convBusy), .memOverflow(memOverflow),
        .timeOverflow(timeOverflow), .clkSrcOneHot(clkSrcOneHot), .seqModeSel(seqModeSel),
        .curMemCtl(curMemCtl), .ovIrqEnable(ovIrqEnable), .tovIrqEnable(tovIrqEnable),
        .irq(irq));

    // ----------------------------------------
    // model and tasks
    // ----------------------------------------
    function automatic logic [31:0] ivExp(logic [15:0] ie, logic [15:0] ifg);
        for (int i = 0; i < 16; i++)
            if (ie[i] && ifg[i])
                return 32'h0000_0006 + 32'(2 * i);
        return 32'h0000_0000;
    endfunction

    // one idle edge first, so a release never meets a new request in one step
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        avs_read      <= ~w;
        avs_write     <= w;
        avs_address   <= a;
        avs_writedata <= {16'h0000, d};
        // only the watchdog ends a wait that never sees waitrequest low
        do
        begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic strobe(input logic dn, input logic [3:0] i, input logic [11:0] v,
                          input logic ov, input logic tov);
        @(posedge sys_clk);
        convResult   <= '{dn, i, v};
        memOverflow  <= ov;
        timeOverflow <= tov;
        @(posedge sys_clk);
        convResult.done <= 1'b0;
        memOverflow     <= 1'b0;
        timeOverflow    <= 1'b0;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // whole run is a few hundred cycles; generous margin
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        {reset_n, avs_read, avs_write, convBusy, memOverflow, timeOverflow} = '0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        convResult = '0;
        n_mismatch = 0;
        check_count = 0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        void'($urandom(59));
        // reset values, unmapped place reads zero
        `CHK(clkSrcOneHot, 4'h1)
        acc(0, `ACR_OFS_IE, 16'h0);
        `CHK(rd, 32'h0)
        acc(0, `ACR_OFS_IFG, 16'h0);
        `CHK(rd, 32'h0)
        acc(0, `ACR_OFS_IV, 16'h0);
        `CHK(rd, 32'h0)
        acc(0, 8'h3c, 16'h0);
        `CHK(rd, 32'h0)
        $display("test reset done");
        // every clock source and mode; busy bit ignores writes
        for (int s = 0; s < 4; s++)
        begin
            acc(1, `ACR_OFS_CTL2, 16'((s << 3) | ((3 - s) << 1) | 1));
            @(negedge sys_clk);
            `CHK(clkSrcOneHot, 4'(1 << s))
            `CHK(seqModeSel, 2'(3 - s))
            acc(0, `ACR_OFS_CTL2, 16'h0);
            `CHK(rd, 32'((s << 3) | ((3 - s) << 1)))
        end
        convBusy <= 1'b1;
        acc(0, `ACR_OFS_CTL2, 16'h0);
        `CHK(rd[0], 1'b1)
        convBusy <= 1'b0;
        $display("test control done");
        // results: flag set on load, cleared by memory access
        ieM = 16'($urandom) | 16'h0001;
        ifgM = 16'h0;
        acc(1, `ACR_OFS_IE, ieM);
        acc(1, `ACR_OFS_MASK, 16'h0001);
        for (int k = 0; k < 5; k++)
        begin
            idx = 4'($urandom_range(15));
            res = 12'($urandom);
            strobe(1'b1, idx, res, 1'b0, 1'b0);
            ifgM[idx] = 1'b1;
            stM = ieM[idx];
            @(negedge sys_clk);
            `CHK(irq, stM)
            acc(0, `ACR_OFS_IFG, 16'h0);
            `CHK(rd, {16'h0, ifgM})
            acc(0, `ACR_OFS_MEM + 8'(4 * idx), 16'h0);
            `CHK(rd, {20'h0, res})
            ifgM[idx] = 1'b0;
            acc(0, `ACR_OFS_IFG, 16'h0);
            `CHK(rd, {16'h0, ifgM})
            acc(1, `ACR_OFS_STAT, 16'h0007);
            @(negedge sys_clk);
            `CHK(irq, 1'b0)
        end
        // control byte read back, then presented for the converting memory
        idx = 4'($urandom);
        res = 12'($urandom);
        acc(1, `ACR_OFS_MCTL + 8'(4 * idx), {8'h00, res[7:0]});
        acc(0, `ACR_OFS_MCTL + 8'(4 * idx), 16'h0);
        `CHK(rd, {24'h0, res[7:0]})
        strobe(1'b0, idx, 12'h000, 1'b0, 1'b0);
        @(negedge sys_clk);
        `CHK(curMemCtl, res[7:0])
        // masked source keeps the line low
        acc(1, `ACR_OFS_MASK, 16'h0000);
        strobe(1'b1, 4'h0, 12'hfff, 1'b0, 1'b0);
        @(negedge sys_clk);
        `CHK(irq, 1'b0)
        acc(1, `ACR_OFS_STAT, 16'h0007);
        acc(0, `ACR_OFS_MEM, 16'h0);
        `CHK(rd, {20'h0, 12'hfff})
        $display("test results done");
        // vector priority over random enables and flags
        for (int k = 0; k < 8; k++)
        begin
            ieM = 16'($urandom);
            ifgM = 16'($urandom);
            acc(1, `ACR_OFS_IE, ieM);
            acc(1, `ACR_OFS_IFG, ifgM);
            acc(0, `ACR_OFS_IV, 16'h0);
            `CHK(rd, ivExp(ieM, ifgM))
        end
        // overflow sources gated by their enables
        acc(1, `ACR_OFS_IE, 16'hffff);
        acc(1, `ACR_OFS_IFG, 16'h0008);
        acc(1, `ACR_OFS_OVCTL, 16'h0000);
        strobe(1'b0, 4'h0, 12'h0, 1'b1, 1'b1);
        acc(0, `ACR_OFS_IV, 16'h0);
        `CHK(rd, 32'h0000_000c)
        acc(1, `ACR_OFS_STAT, 16'h0007);
        acc(1, `ACR_OFS_OVCTL, 16'h000c);
        @(negedge sys_clk);
        `CHK({ovIrqEnable, tovIrqEnable}, 2'b11)
        strobe(1'b0, 4'h0, 12'h0, 1'b1, 1'b1);
        acc(0, `ACR_OFS_IV, 16'h0);
        `CHK(rd, 32'h0000_0002)
        acc(0, `ACR_OFS_IV, 16'h0);
        `CHK(rd, 32'h0000_0004)
        acc(0, `ACR_OFS_IV, 16'h0);
        `CHK(rd, 32'h0000_000c)
        $display("test vector done");
        end_sim();
    end

endmodule

// ===== src/acr_params.svh
/*
 register offsets, field positions, reset values for the converter
 result and interrupt control block; assumes byte addressing on a
 32-bit avalon slave port, one aligned word per register.
*/
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ----------------------------------------
// offsets (byte addresses)
// ----------------------------------------
`define ACR_OFS_CTL2    8'h00
`define ACR_OFS_IE      8'h04
`define ACR_OFS_IFG     8'h08
`define ACR_OFS_IV      8'h0c
`define ACR_OFS_OVCTL   8'h10
`define ACR_OFS_STAT    8'h14
`define ACR_OFS_MASK    8'h18
`define ACR_OFS_MEM     8'h40
`define ACR_OFS_MCTL    8'h80
`define ACR_REGION_MSK  8'hc0

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACR_CLKSEL_HI   4
`define ACR_CLKSEL_LO   3
`define ACR_MODE_HI     2
`define ACR_MODE_LO     1
`define ACR_BUSY_BIT    0
`define ACR_OVIE_BIT    3
`define ACR_TOVIE_BIT   2
`define ACR_ST_RES      0
`define ACR_ST_OV       1
`define ACR_ST_TOV      2

// ----------------------------------------
// values
// ----------------------------------------
`define ACR_RST_WORD    16'h0000
`define ACR_IV_NONE     16'h0000
`define ACR_IV_OV       16'h0002
`define ACR_IV_TOV      16'h0004
`define ACR_IV_MEM0     16'h0006

`endif

// ===== src/acr_pkg.sv
/*
 types of the converter result and interrupt control block;
 assumes acr_params.svh supplies the numbers.
*/
package acr_pkg;

    typedef enum logic [1:0] {
        ACR_SINGLE,
        ACR_SEQUENCE,
        ACR_REPEAT_SINGLE,
        ACR_REPEAT_SEQUENCE
    } acr_mode_t;

    typedef struct packed {
        logic [1:0]        clkSel;
        acr_mode_t         seqMode;
        logic [15:0]       irqEn;
        logic [15:0]       irqFlag;
        logic [15:0][11:0] mem;
        logic [15:0][7:0]  mctl;
        logic              ovIe;
        logic              tovIe;
        logic [2:0]        status;
        logic [2:0]        mask;
        logic              ack;
        logic [15:0]       rdata;
        logic [7:0]        curCtl;
    } acr_state_t;

    typedef struct packed {
        logic        done;
        logic [3:0]  index;
        logic [11:0] result;
    } acr_result_t;

endpackage

// ===== src/acr_top.sv
/*
 register side of a 12-bit converter: clock/mode control, sixteen
 result memories and control bytes, result flags, vector and one
 interrupt line. assumes the converter core runs on sys_clk and
 hands results as one-cycle strobes.
*/
`timescale 1ns/100ps
`include "acr_params.svh"

module acr_top
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // converter core
    input  acr_pkg::acr_result_t convResult,
    input  wire logic        convBusy,
    input  wire logic        memOverflow,
    input  wire logic        timeOverflow,
    output logic [3:0]       clkSrcOneHot,
    output logic [1:0]       seqModeSel,
    output logic [7:0]       curMemCtl,
    output logic             ovIrqEnable,
    output logic             tovIrqEnable,
    // interrupt
    output logic             irq
);

    acr_pkg::acr_state_t acrState_ff;
    acr_pkg::acr_state_t nxt_acrState;
    logic                req;
    logic                accept;
    logic [7:0]          regionAddr;
    logic [3:0]          slot;
    logic [15:0]         wdata;
    logic [15:0]         vector;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] prioVector(
        input logic        ovPend,
        input logic        tovPend,
        input logic [15:0] pend
    );
        logic [15:0] v;
        v = `ACR_IV_NONE;
        for (int i = 15; i >= 0; i--)
        begin
            if (pend[i])
            begin
                v = `ACR_IV_MEM0 + 16'(2 * i);
            end
        end
        if (tovPend)
        begin
            v = `ACR_IV_TOV;
        end
        if (ovPend)
        begin
            v = `ACR_IV_OV;
        end
        return v;
    endfunction

    assign req        = avs_read | avs_write;
    assign accept     = req & acrState_ff.ack;
    assign regionAddr = avs_address & `ACR_REGION_MSK;
    assign slot       = avs_address[5:2];
    assign wdata      = avs_writedata[15:0];
    // pending memory sources only count when enabled
    assign vector     = prioVector(acrState_ff.status[`ACR_ST_OV],
                                   acrState_ff.status[`ACR_ST_TOV],
                                   acrState_ff.irqFlag & acrState_ff.irqEn);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [2:0] stSet;
        stSet        = 3'h0;
        nxt_acrState = acrState_ff;
        // one wait cycle gives the read data a full cycle to settle
        nxt_acrState.ack = req & ~acrState_ff.ack;
        if (req & ~acrState_ff.ack)
        begin
            nxt_acrState.rdata = `ACR_RST_WORD;
            if (regionAddr == `ACR_OFS_MEM)
            begin
                nxt_acrState.rdata = {4'h0, acrState_ff.mem[slot]};
            end
            else if (regionAddr == `ACR_OFS_MCTL)
            begin
                nxt_acrState.rdata = {8'h00, acrState_ff.mctl[slot]};
            end
            else if (avs_address == `ACR_OFS_CTL2)
            begin
                nxt_acrState.rdata[`ACR_CLKSEL_HI:`ACR_CLKSEL_LO] = acrState_ff.clkSel;
                nxt_acrState.rdata[`ACR_MODE_HI:`ACR_MODE_LO] = acrState_ff.seqMode;
                nxt_acrState.rdata[`ACR_BUSY_BIT] = convBusy;
            end
            else if (avs_address == `ACR_OFS_IE)
            begin
                nxt_acrState.rdata = acrState_ff.irqEn;
            end
            else if (avs_address == `ACR_OFS_IFG)
            begin
                nxt_acrState.rdata = acrState_ff.irqFlag;
            end
            else if (avs_address == `ACR_OFS_IV)
            begin
                nxt_acrState.rdata = vector;
            end
            else if (avs_address == `ACR_OFS_OVCTL)
            begin
                nxt_acrState.rdata[`ACR_OVIE_BIT]  = acrState_ff.ovIe;
                nxt_acrState.rdata[`ACR_TOVIE_BIT] = acrState_ff.tovIe;
            end
            else if (avs_address == `ACR_OFS_STAT)
            begin
                nxt_acrState.rdata = {13'h0, acrState_ff.status};
            end
            else if (avs_address == `ACR_OFS_MASK)
            begin
                nxt_acrState.rdata = {13'h0, acrState_ff.mask};
            end
        end
        // clears first, hardware sets applied last so they win
        if (accept)
        begin
            if (regionAddr == `ACR_OFS_MEM)
            begin
                nxt_acrState.irqFlag[slot] = 1'b0;
                if (avs_write)
                begin
                    nxt_acrState.mem[slot] = wdata[11:0];
                end
            end
            else if (avs_write)
            begin
                if (regionAddr == `ACR_OFS_MCTL)
                begin
                    nxt_acrState.mctl[slot] = wdata[7:0];
                end
                else if (avs_address == `ACR_OFS_CTL2)
                begin
                    nxt_acrState.clkSel = wdata[`ACR_CLKSEL_HI:`ACR_CLKSEL_LO];
                    nxt_acrState.seqMode =
                        acr_pkg::acr_mode_t'(wdata[`ACR_MODE_HI:`ACR_MODE_LO]);
                end
                else if (avs_address == `ACR_OFS_IE)
                begin
                    nxt_acrState.irqEn = wdata;
                end
                else if (avs_address == `ACR_OFS_IFG)
                begin
                    nxt_acrState.irqFlag = wdata;
                end
                else if (avs_address == `ACR_OFS_OVCTL)
                begin
                    nxt_acrState.ovIe  = wdata[`ACR_OVIE_BIT];
                    nxt_acrState.tovIe = wdata[`ACR_TOVIE_BIT];
                end
                else if (avs_address == `ACR_OFS_STAT)
                begin
                    nxt_acrState.status = acrState_ff.status & ~wdata[2:0];
                end
                else if (avs_address == `ACR_OFS_MASK)
                begin
                    nxt_acrState.mask = wdata[2:0];
                end
            end
            else if (avs_address == `ACR_OFS_IV)
            begin
                // reading the vector acknowledges an overflow source
                if (vector == `ACR_IV_OV)
                begin
                    nxt_acrState.status[`ACR_ST_OV] = 1'b0;
                end
                else if (vector == `ACR_IV_TOV)
                begin
                    nxt_acrState.status[`ACR_ST_TOV] = 1'b0;
                end
            end
        end
        if (convResult.done)
        begin
            nxt_acrState.mem[convResult.index]     = convResult.result;
            nxt_acrState.irqFlag[convResult.index] = 1'b1;
            stSet[`ACR_ST_RES] = acrState_ff.irqEn[convResult.index];
        end
        stSet[`ACR_ST_OV]  = memOverflow & acrState_ff.ovIe;
        stSet[`ACR_ST_TOV] = timeOverflow & acrState_ff.tovIe;
        nxt_acrState.status = nxt_acrState.status | stSet;
        nxt_acrState.curCtl = acrState_ff.mctl[convResult.index];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            acrState_ff <= '0;
        end
        else
        begin
            acrState_ff <= nxt_acrState;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata    = {16'h0000, acrState_ff.rdata};
    assign avs_waitrequest = req & ~acrState_ff.ack;
    assign clkSrcOneHot    = 4'h1 << acrState_ff.clkSel;
    assign seqModeSel      = acrState_ff.seqMode;
    assign curMemCtl       = acrState_ff.curCtl;
    assign ovIrqEnable     = acrState_ff.ovIe;
    assign tovIrqEnable    = acrState_ff.tovIe;
    assign irq             = |(acrState_ff.status & acrState_ff.mask);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_clk_onehot: assert property (
        clkSrcOneHot[acrState_ff.clkSel] && $onehot(clkSrcOneHot))
        else $error("clock source select not decoded");
    a_mode_write: assert property (
        accept && avs_write && avs_address == `ACR_OFS_CTL2
        |=> seqModeSel == $past(wdata[2:1]))
        else $error("mode field not taken from write");
    a_mode_code: assert property (
        accept && avs_write && avs_address == `ACR_OFS_CTL2
        && wdata[`ACR_MODE_HI:`ACR_MODE_LO] == 2'b11
        |=> acrState_ff.seqMode == acr_pkg::ACR_REPEAT_SEQUENCE && seqModeSel == 2'b11)
        else $error("mode encoding wrong");
    a_busy_read: assert property (
        accept && avs_read && avs_address == `ACR_OFS_CTL2
        |-> avs_readdata[0] == $past(convBusy))
        else $error("busy bit does not follow converter");
    a_mem_upper: assert property (
        accept && avs_read && regionAddr == `ACR_OFS_MEM |-> avs_readdata[15:12] == 4'h0)
        else $error("result upper bits not zero");
    a_res_gate: assert property (
        convResult.done && !acrState_ff.irqEn[convResult.index]
        && !acrState_ff.status[0] |=> !acrState_ff.status[0])
        else $error("disabled memory raised request");
    a_flag_set: assert property (
        convResult.done |=> acrState_ff.irqFlag[$past(convResult.index)])
        else $error("flag not set on load");
    a_flag_clr: assert property (
        accept && regionAddr == `ACR_OFS_MEM && !convResult.done
        |=> !acrState_ff.irqFlag[$past(slot)])
        else $error("flag not cleared on access");
    a_vec_prio: assert property (
        acrState_ff.status[`ACR_ST_OV] |-> vector == `ACR_IV_OV)
        else $error("overflow not highest priority");
    a_ov_gate: assert property (
        !acrState_ff.ovIe && !acrState_ff.status[1] && !accept |=> !acrState_ff.status[1])
        else $error("overflow request while disabled");
    a_tov_gate: assert property (
        !acrState_ff.tovIe && !acrState_ff.status[2] && !accept |=> !acrState_ff.status[2])
        else $error("time overflow request while disabled");
    a_vec_none: assert property (
        acrState_ff.status[2:1] == 2'b00
        && (acrState_ff.irqFlag & acrState_ff.irqEn) == 16'h0000 |-> vector == `ACR_IV_NONE)
        else $error("vector not zero while idle");
    a_flag_write: assert property (
        accept && avs_write && avs_address == `ACR_OFS_IFG && !convResult.done
        |=> acrState_ff.irqFlag == $past(wdata))
        else $error("flag register write not taken");
    a_res_set: assert property (
        convResult.done && acrState_ff.irqEn[convResult.index] |=> acrState_ff.status[0])
        else $error("enabled memory raised no request");
    a_bus_wait: assert property (
        req && !avs_waitrequest |=> !acrState_ff.ack)
        else $error("waitrequest timing broken");

    c_result_irq: cover property (convResult.done ##1 irq);
    c_vec_read: cover property (accept && avs_address == `ACR_OFS_IV && vector != 16'h0000);
    c_set_clear: cover property (convResult.done && accept && regionAddr == `ACR_OFS_MEM);
    c_both_ovf: cover property (acrState_ff.status[2:1] == 2'b11);
    c_busy_read: cover property (accept && avs_read && avs_address == `ACR_OFS_CTL2 && convBusy);

endmodule
